// ### rtl/serl_exception.sv
// Exception and answer logic for the 16-bit command/answer link
// Assumes register contents, data path and fault detectors sit outside
//
// Functional notes
// - Clock high at select edges: framing error
// - Not sixteen rising edges: framing error
// - Parity failure: SPI error
// - Acceleration frame needs bit15, bits3-11 zero
// - Register read needs bits 0-7 zero
// - SPI error: error answer, no arming
// - MISO readback mismatch sets sticky flag
// - Readback fault drops acceleration request
// - Readback fault still performs register write
// - Readback fault drops read, status kept
// - Readback flag holds until status read
// - Bad axis/config: invalid acceleration, one frame
// - Writes to unwritable addresses are refused
// - Lock refuses writes except control register
// - Reads of unreadable addresses are refused
// - Init/reset flags: error answer, pcm off
// - CRC, self-test, logic faults set internal flag
// - CRC fault answer; locked array CRC sticky
// - Shadow-array CRC fault never clears
// - Self-test fault answer, clears on status read
// - Over-range marks status 10, one extra
// - After reset: SPI error, then invalid acceleration
// - Command frames use odd parity
// - Fixed priority picks the answer
`include "serl_regs.svh"
module serl_exception #(
	parameter logic [15:0] RSP_SPI_ERR  = `SERL_RSP_SPI_ERR,
	parameter logic [15:0] RSP_INV_ACC  = `SERL_RSP_INV_ACC,
	parameter logic [15:0] RSP_MISO_ERR = `SERL_RSP_MISO_ERR,
	parameter logic [15:0] RSP_INT_ERR  = `SERL_RSP_INT_ERR,
	parameter logic [15:0] RSP_ST_ERR   = `SERL_RSP_ST_ERR,
	parameter logic [15:0] RSP_INV_REG  = `SERL_RSP_INV_REG,
	parameter logic [15:0] RSP_ACC_BASE = `SERL_RSP_ACC_BASE,
	parameter logic [15:0] RSP_RD_BASE  = `SERL_RSP_RD_BASE,
	parameter logic [15:0] RSP_WR_BASE  = `SERL_RSP_WR_BASE
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	// Link pins
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        mosi_i,
	input  wire logic        miso_fb_i,
	output logic             miso_o,
	output logic             miso_oe_o,
	// Configuration
	input  wire logic        config_lock_i,
	input  wire logic        cfg_signed_i,
	input  wire logic        cfg_arm_i,
	// Data and fault sources
	input  wire logic [9:0]  accel_data_i,
	input  wire logic        init_busy_i,
	input  wire logic        otp_crc_fail_i,
	input  wire logic        wr_crc_fail_i,
	input  wire logic        self_test_fail_i,
	input  wire logic        logic_fault_i,
	input  wire logic        offset_ovr_i,
	input  wire logic        mod_ovr_i,
	// Register access
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic [4:0]       reg_addr_o,
	output logic [7:0]       reg_wdata_o,
	input  wire logic [7:0]  reg_rdata_i,
	// Effects and status
	output logic             arm_update_o,
	output logic             pcm_enable_o,
	output logic [7:0]       device_status_o
);
	logic                     done;
	serl_pkg::serl_frame_type fr;
	logic [15:0]              w;
	logic [`SERL_ADDR_W-1:0]  addr;
	logic                     acc, rd, wr;
	logic                     parity_err, acc_fmt_err, rd_fmt_err, spi_err;
	logic                     cfg_mis, inv_acc, inv_reg, ovr_now, stat_rd;
	logic [7:0]               status, rd_data;

	logic [15:0] resp_r, resp_nxt;
	logic        wr_r, wr_nxt, rd_r, rd_nxt, arm_r, arm_nxt, pcm_r, pcm_nxt;
	logic [4:0]  addr_r, addr_nxt;
	logic [7:0]  wdata_r, wdata_nxt;
	logic        init_r, init_nxt, rst_r, rst_nxt, miso_f_r, miso_f_nxt;
	logic        otp_r, otp_nxt, wrcrc_r, wrcrc_nxt, st_r, st_nxt;
	logic        lgc_r, lgc_nxt, off_r, off_nxt, movr_r, movr_nxt;
	logic        tail_r, tail_nxt;

	function automatic logic addr_ok(input logic [31:0] mask, input logic [4:0] a);
		addr_ok = mask[a];
	endfunction

	serl_frame_shift u_shift (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.sclk_i    (sclk_i),
		.cs_n_i    (cs_n_i),
		.mosi_i    (mosi_i),
		.miso_fb_i (miso_fb_i),
		.miso_o    (miso_o),
		.miso_oe_o (miso_oe_o),
		.tx_word_i (resp_r),
		.done_o    (done),
		.frame_o   (fr)
	);

	assign w    = fr.word;
	assign addr = w[`SERL_ADDR_HI:`SERL_ADDR_LO];
	assign acc  = w[`SERL_BIT_ACC];
	assign rd   = ~acc & ~w[`SERL_BIT_SEL];
	assign wr   = ~acc & w[`SERL_BIT_SEL];

	assign parity_err  = ~(^w);
	assign acc_fmt_err = acc & (w[`SERL_BIT_FIXED0] | (|w[`SERL_ACC_ZERO_HI:`SERL_ACC_ZERO_LO]));
	assign rd_fmt_err  = rd & (|w[`SERL_DATA_HI:0]);
	assign spi_err     = fr.frame_err | parity_err | acc_fmt_err | rd_fmt_err;

	assign cfg_mis = (w[`SERL_BIT_SGN] != cfg_signed_i) | (w[`SERL_BIT_ARM] != cfg_arm_i);
	assign inv_acc = acc & (w[`SERL_BIT_SEL] | cfg_mis);
	assign inv_reg = (wr & (~addr_ok(`SERL_WR_MASK, addr)
		| (config_lock_i & (addr != `SERL_ADDR_CONTROL))))
		| (rd & ~addr_ok(`SERL_RD_MASK, addr));

	assign ovr_now = offset_ovr_i | mod_ovr_i;
	assign stat_rd = rd_r & (addr_r == `SERL_ADDR_STATUS);

	always_comb begin
		status                = 8'h00;
		status[`SERL_ST_INIT]  = init_r;
		status[`SERL_ST_RESET] = rst_r;
		status[`SERL_ST_INT]   = otp_r | wrcrc_r | st_r | lgc_r;
		status[`SERL_ST_MISO]  = miso_f_r;
		status[`SERL_ST_OFF]   = off_r;
		status[`SERL_ST_MOVR]  = movr_r;
		rd_data = (addr_r == `SERL_ADDR_STATUS) ? status : reg_rdata_i;
	end

	// Answer selection and register effects
	always_comb begin
		resp_nxt  = resp_r;
		wr_nxt    = 1'b0;
		rd_nxt    = 1'b0;
		arm_nxt   = 1'b0;
		addr_nxt  = addr_r;
		wdata_nxt = wdata_r;
		tail_nxt  = tail_r;
		// pcm off while init or reset flag
		pcm_nxt   = ~(init_r | rst_r);
		if (done) begin
			addr_nxt  = addr;
			wdata_nxt = w[`SERL_DATA_HI:0];
			if (spi_err) begin
				resp_nxt = RSP_SPI_ERR;
			end else if (fr.miso_err) begin
				resp_nxt = RSP_MISO_ERR;
				wr_nxt   = wr & ~inv_reg;
			end else if (acc) begin
				if (inv_acc)
					resp_nxt = RSP_INV_ACC;
				else if (init_r)
					resp_nxt = RSP_INT_ERR;
				else if (rst_r)
					resp_nxt = RSP_INV_ACC;
				else if (otp_r | wrcrc_r)
					resp_nxt = RSP_INT_ERR;
				else if (st_r)
					resp_nxt = RSP_ST_ERR;
				else if (lgc_r)
					resp_nxt = RSP_INT_ERR;
				else begin
					resp_nxt = RSP_ACC_BASE | {4'h0,
						(ovr_now | tail_r) ? `SERL_S_OVR : `SERL_S_NORMAL, accel_data_i};
					tail_nxt = ovr_now;
					arm_nxt  = 1'b1;
				end
			end else if (inv_reg) begin
				resp_nxt = RSP_INV_REG;
			end else if (wr) begin
				resp_nxt = RSP_WR_BASE | {8'h00, w[`SERL_DATA_HI:0]};
				wr_nxt   = 1'b1;
			end else begin
				resp_nxt = RSP_RD_BASE;
				rd_nxt   = 1'b1;
			end
		end
		if (rd_r)
			resp_nxt = RSP_RD_BASE | {8'h00, rd_data};
	end

	// Sticky flags except init, which follows init_busy_i; a set beats a same-cycle clear
	always_comb begin
		init_nxt   = init_busy_i;
		// reset flag cleared by status read
		rst_nxt    = rst_r & ~stat_rd;
		miso_f_nxt = (miso_f_r & ~stat_rd) | (done & fr.miso_err);
		otp_nxt    = otp_r | otp_crc_fail_i;
		// locked array CRC survives status read
		wrcrc_nxt  = (wrcrc_r & ~(stat_rd & ~config_lock_i)) | wr_crc_fail_i;
		st_nxt     = (st_r & ~stat_rd) | self_test_fail_i;
		lgc_nxt    = (lgc_r & ~stat_rd) | logic_fault_i;
		off_nxt    = (off_r & ~stat_rd) | offset_ovr_i;
		movr_nxt   = (movr_r & ~stat_rd) | mod_ovr_i;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			resp_r   <= RSP_SPI_ERR;
			wr_r     <= 1'b0;
			rd_r     <= 1'b0;
			arm_r    <= 1'b0;
			pcm_r    <= 1'b0;
			addr_r   <= '0;
			wdata_r  <= '0;
			tail_r   <= 1'b0;
			init_r   <= 1'b1;
			rst_r    <= 1'b1;
			miso_f_r <= 1'b0;
			otp_r    <= 1'b0;
			wrcrc_r  <= 1'b0;
			st_r     <= 1'b0;
			lgc_r    <= 1'b0;
			off_r    <= 1'b0;
			movr_r   <= 1'b0;
		end else begin
			resp_r   <= resp_nxt;
			wr_r     <= wr_nxt;
			rd_r     <= rd_nxt;
			arm_r    <= arm_nxt;
			pcm_r    <= pcm_nxt;
			addr_r   <= addr_nxt;
			wdata_r  <= wdata_nxt;
			tail_r   <= tail_nxt;
			init_r   <= init_nxt;
			rst_r    <= rst_nxt;
			miso_f_r <= miso_f_nxt;
			otp_r    <= otp_nxt;
			wrcrc_r  <= wrcrc_nxt;
			st_r     <= st_nxt;
			lgc_r    <= lgc_nxt;
			off_r    <= off_nxt;
			movr_r   <= movr_nxt;
		end
	end

	assign reg_wr_o        = wr_r;
	assign reg_rd_o        = rd_r;
	assign reg_addr_o      = addr_r;
	assign reg_wdata_o     = wdata_r;
	assign arm_update_o    = arm_r;
	assign pcm_enable_o    = pcm_r;
	assign device_status_o = status;

	default clocking dc @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	spi_err_resp_a: assert property (done && fr.frame_err |=>
		resp_r == RSP_SPI_ERR && !arm_update_o && !reg_wr_o && !reg_rd_o)
		else $error("framing error not answered");
	parity_err_a: assert property (done && !(^w) |=> resp_r == RSP_SPI_ERR)
		else $error("parity error not answered");
	acc_fmt_a: assert property (done && acc && w[15] |=>
		resp_r == RSP_SPI_ERR && !arm_update_o)
		else $error("bad acceleration frame accepted");
	rd_fmt_a: assert property (done && rd && w[7:0] != 8'h00 |=> !reg_rd_o)
		else $error("bad read frame performed");
	miso_wr_a: assert property (done && !spi_err && fr.miso_err && wr && !inv_reg
		|=> reg_wr_o && resp_r == RSP_MISO_ERR ##1 miso_f_r)
		else $error("write with readback fault mishandled");
	miso_hold_a: assert property (miso_f_r && !stat_rd |=> miso_f_r)
		else $error("readback flag dropped early");
	lock_write_a: assert property (done && !spi_err && !fr.miso_err && wr
		&& config_lock_i && addr != 5'h10 |=> !reg_wr_o && resp_r == RSP_INV_REG)
		else $error("locked write performed");
	bad_read_a: assert property (done && !spi_err && !fr.miso_err && rd
		&& addr == 5'h07 |=> !reg_rd_o && resp_r == RSP_INV_REG)
		else $error("unreadable address read");
	pcm_off_a: assert property ((init_r || rst_r) |=> !pcm_enable_o)
		else $error("pcm enabled during init or reset");
	otp_keep_a: assert property (otp_r |=> otp_r [*8])
		else $error("shadow CRC fault cleared");
	reset_acc_a: assert property (done && !spi_err && !fr.miso_err && acc && rst_r && !init_r
		|=> resp_r == RSP_INV_ACC && !arm_update_o)
		else $error("acceleration served with reset flag");

	valid_acc_c: cover property (arm_update_o);
	status_read_c: cover property (stat_rd && miso_f_r);
	ovr_tail_c: cover property (done && acc && tail_r && !ovr_now ##1 arm_update_o);
endmodule

// ### rtl/serl_frame_shift.sv
// Serial frame shifter: synchronises the link pins, shifts one frame in and out
// Assumes SCLK idles low and is far slower than ref_clk_i
`include "serl_regs.svh"
module serl_frame_shift (
	// Clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        resetn_i,
	// Link pins
	input  wire logic                        sclk_i,
	input  wire logic                        cs_n_i,
	input  wire logic                        mosi_i,
	input  wire logic                        miso_fb_i,
	output logic                             miso_o,
	output logic                             miso_oe_o,
	// Frame side
	input  wire logic [`SERL_FRAME_BITS-1:0] tx_word_i,
	output logic                             done_o,
	output serl_pkg::serl_frame_type         frame_o
);
	logic [2:0]                  sclk_s;
	logic [2:0]                  cs_s;
	logic [1:0]                  mosi_s;
	logic [1:0]                  fb_s;
	serl_pkg::serl_link_state_type st_r, st_nxt;
	logic [`SERL_CNT_W-1:0]      cnt_r, cnt_nxt;
	logic [`SERL_FRAME_BITS-1:0] rx_r, rx_nxt;
	logic [`SERL_FRAME_BITS-1:0] tx_r, tx_nxt;
	logic                        err_r, err_nxt;
	logic                        mis_r, mis_nxt;
	logic                        miso_r, miso_nxt;
	logic                        oe_r, oe_nxt;
	logic                        done_r, done_nxt;
	serl_pkg::serl_frame_type    frame_r, frame_nxt;
	logic                        sclk_rise, sclk_fall, cs_assert, cs_release;

	// Two-stage synchronisers, third stage only for edge finding
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_s <= 3'h0;
			cs_s   <= 3'h7;
			mosi_s <= 2'h0;
			fb_s   <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk_i};
			cs_s   <= {cs_s[1:0], cs_n_i};
			mosi_s <= {mosi_s[0], mosi_i};
			fb_s   <= {fb_s[0], miso_fb_i};
		end
	end

	assign sclk_rise  = sclk_s[1] & ~sclk_s[2];
	assign sclk_fall  = ~sclk_s[1] & sclk_s[2];
	assign cs_assert  = ~cs_s[1] & cs_s[2];
	assign cs_release = cs_s[1] & ~cs_s[2];

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		rx_nxt    = rx_r;
		tx_nxt    = tx_r;
		err_nxt   = err_r;
		mis_nxt   = mis_r;
		miso_nxt  = miso_r;
		oe_nxt    = oe_r;
		done_nxt  = 1'b0;
		frame_nxt = frame_r;
		case (st_r)
			serl_pkg::serl_lk_idle: begin
				if (cs_assert) begin
					st_nxt   = serl_pkg::serl_lk_frame;
					cnt_nxt  = '0;
					err_nxt  = sclk_s[1];
					mis_nxt  = 1'b0;
					tx_nxt   = tx_word_i;
					miso_nxt = tx_word_i[`SERL_FRAME_BITS-1];
					oe_nxt   = 1'b1;
				end
			end
			serl_pkg::serl_lk_frame: begin
				if (sclk_rise) begin
					rx_nxt = {rx_r[`SERL_FRAME_BITS-2:0], mosi_s[1]};
					if (cnt_r != '1)
						cnt_nxt = cnt_r + 1'b1;
					if (fb_s[1] != miso_r)
						mis_nxt = 1'b1;
				end
				// A fall before the first rise keeps the first bit
				if (sclk_fall && cnt_r != '0) begin
					tx_nxt   = {tx_r[`SERL_FRAME_BITS-2:0], 1'b0};
					miso_nxt = tx_r[`SERL_FRAME_BITS-2];
				end
				if (cs_release) begin
					st_nxt             = serl_pkg::serl_lk_idle;
					oe_nxt             = 1'b0;
					miso_nxt           = 1'b0;
					done_nxt           = 1'b1;
					frame_nxt.word     = rx_nxt;
					frame_nxt.frame_err = err_r | sclk_s[1] | (cnt_nxt != `SERL_CNT_FULL);
					frame_nxt.miso_err  = mis_nxt;
				end
			end
			default: begin
				st_nxt = serl_pkg::serl_lk_idle;
				oe_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r    <= serl_pkg::serl_lk_idle;
			cnt_r   <= '0;
			rx_r    <= '0;
			tx_r    <= '0;
			err_r   <= 1'b0;
			mis_r   <= 1'b0;
			miso_r  <= 1'b0;
			oe_r    <= 1'b0;
			done_r  <= 1'b0;
			frame_r <= '0;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			rx_r    <= rx_nxt;
			tx_r    <= tx_nxt;
			err_r   <= err_nxt;
			mis_r   <= mis_nxt;
			miso_r  <= miso_nxt;
			oe_r    <= oe_nxt;
			done_r  <= done_nxt;
			frame_r <= frame_nxt;
		end
	end

	assign miso_o    = miso_r;
	assign miso_oe_o = oe_r;
	assign done_o    = done_r;
	assign frame_o   = frame_r;
endmodule

// ### rtl/serl_pkg.sv
// Types shared by the frame shifter and the exception logic
// Assumes serl_regs.svh is on the include path
`include "serl_regs.svh"
package serl_pkg;
	typedef enum logic [1:0] {
		serl_lk_idle  = 2'b01,
		serl_lk_frame = 2'b10
	} serl_link_state_type;

	typedef struct packed {
		logic [`SERL_FRAME_BITS-1:0] word;
		logic                        frame_err;
		logic                        miso_err;
	} serl_frame_type;
endpackage

// ### rtl/serl_regs.svh
// Frame layout, register map, status layout and default answer codes
// Assumes 16-bit frames, MSB first, five-bit register addresses
`ifndef SERL_REGS_SVH
`define SERL_REGS_SVH

// Frame fields
`define SERL_FRAME_BITS     16
`define SERL_CNT_W          5
`define SERL_CNT_FULL       5'h10
`define SERL_BIT_FIXED0     15
`define SERL_BIT_ACC        14
`define SERL_BIT_SEL        13
`define SERL_BIT_OFS        12
`define SERL_ACC_ZERO_HI    11
`define SERL_ACC_ZERO_LO    3
`define SERL_BIT_SGN        2
`define SERL_BIT_ARM        1
`define SERL_ADDR_HI        12
`define SERL_ADDR_LO        8
`define SERL_DATA_HI        7

// Register map
`define SERL_ADDR_W         5
`define SERL_ADDR_STATUS    5'h0e
`define SERL_ADDR_CONTROL   5'h10
`define SERL_WR_MASK        32'h0001_157f
`define SERL_RD_MASK        32'h0015_5f7f

// Status register bit positions
`define SERL_ST_INIT        0
`define SERL_ST_RESET       1
`define SERL_ST_INT         2
`define SERL_ST_MISO        3
`define SERL_ST_OFF         4
`define SERL_ST_MOVR        5

// Answer codes, arbitrary defaults
`define SERL_RSP_SPI_ERR    16'hc001
`define SERL_RSP_INV_ACC    16'hc002
`define SERL_RSP_MISO_ERR   16'hc003
`define SERL_RSP_INT_ERR    16'hc004
`define SERL_RSP_ST_ERR     16'hc005
`define SERL_RSP_INV_REG    16'hc006
`define SERL_RSP_ACC_BASE   16'h4000
`define SERL_RSP_RD_BASE    16'h8000
`define SERL_RSP_WR_BASE    16'h8100
`define SERL_S_NORMAL       2'h1
`define SERL_S_OVR          2'h2

`endif

// ### test/serl_exception_tb.sv
// Self-checking bench for the exception and answer logic
// Assumes a pulled-up MISO wire; inj corrupts only the readback path
`include "serl_regs.svh"
module serl_exception_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk_i, resetn_i, sclk, cs_n, mosi, miso, miso_fb, miso_o, miso_oe;
	logic        inj, clr, lock, sgn, arm, init_busy, offo, modo, lgf;
	logic        reg_wr, reg_rd, arm_upd, pcm_en;
	logic [2:0]  flt, seen;
	logic [9:0]  acc;
	logic [7:0]  rdat, wdat, stat;
	logic [4:0]  addr;
	logic [15:0] pend, a0;
	logic [31:0] seed, v;
	logic [15:0] bad [8];
	logic [4:0]  bad_a [9];
	int          errors, comparisons, cyc;

	serl_exception serl_exception_i (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.mosi_i(mosi), .miso_fb_i(miso_fb), .miso_o(miso_o), .miso_oe_o(miso_oe),
		.config_lock_i(lock), .cfg_signed_i(sgn), .cfg_arm_i(arm), .accel_data_i(acc),
		.init_busy_i(init_busy), .otp_crc_fail_i(flt[2]), .wr_crc_fail_i(flt[1]),
		.self_test_fail_i(flt[0]), .logic_fault_i(lgf), .offset_ovr_i(offo),
		.mod_ovr_i(modo), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr),
		.reg_wdata_o(wdat), .reg_rdata_i(rdat), .arm_update_o(arm_upd),
		.pcm_enable_o(pcm_en), .device_status_o(stat)
	);
	serl_host_model serl_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso));
	assign miso    = miso_oe ? miso_o : 1'b1;
	assign miso_fb = miso ^ inj;

	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) seen <= clr ? 3'b000 : seen | {arm_upd, reg_wr, reg_rd};
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			errors++;
			report_and_stop();
		end
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] rf(input logic wr, input logic [4:0] a, input logic [7:0] d);
		logic [15:0] w;
		w = {2'b00, wr, a, d};
		w[15] = ~^w[14:0];
		return w;
	endfunction
	function automatic logic [15:0] af(input logic ax, input logic oc, input logic sd,
		input logic am);
		logic [15:0] w;
		w = {2'b01, ax, oc, 9'h000, sd, am, 1'b0};
		w[0] = ~^w[15:1];
		return w;
	endfunction
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Each frame returns the answer to the previous one
	task automatic step(input logic [15:0] cmd, input logic [15:0] nxt, input logic [2:0] pul,
		input int rises = 16, input int mode = 0, input logic [2:0] m = 3'b111);
		logic [15:0] rsp;
		@(posedge ref_clk_i) clr <= 1'b1;
		@(posedge ref_clk_i) clr <= 1'b0;
		#1.3;
		serl_host_model_i.xfer(cmd, rises, mode, rsp);
		// Short or long frames see the answer shifted by one place
		check("answer", rsp, rises < 16 ? pend >> 1 : rises > 16 ? pend << 1 : pend);
		check("pulses", {13'h0000, seen & m}, {13'h0000, pul & m});
		pend = nxt;
		@(posedge ref_clk_i);
	endtask
	task automatic sr(input logic [7:0] x);
		step(rf(1'b0, 5'h0e, 8'h00), {8'h80, x}, 3'b001);
	endtask
	task automatic st(input logic [7:0] x);
		check("status", {8'h00, stat}, {8'h00, x});
	endtask
	task automatic ms(input logic [15:0] cmd, input logic [2:0] pul, input logic [2:0] m = 3'b111);
		inj <= 1'b1;
		step(cmd, `SERL_RSP_MISO_ERR, pul, 16, 0, m);
		inj <= 1'b0;
	endtask
	task automatic pf(input logic [2:0] f);
		flt <= f;
		repeat (2) @(posedge ref_clk_i);
		flt <= 3'b000;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		seed = 32'hb0741f13;
		{resetn_i, inj, clr, lock, sgn, arm, offo, modo, lgf, flt, seen} = '0;
		init_busy = 1'b1;
		{acc, rdat} = '0;
		errors = 0;
		comparisons = 0;
		cyc = 0;
		pend = `SERL_RSP_SPI_ERR;
		a0 = af(1'b0, 1'b0, 1'b0, 1'b0);
		bad = '{16'h0001, 16'h8001, 16'h0009, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		bad_a = '{5'h0d, 5'h0f, 5'h11, 5'h13, 5'h07, 5'h0d, 5'h0f, 5'h11, 5'h13};
		repeat (20) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		step(a0, `SERL_RSP_INT_ERR, 3'b000);
		check("pcm", {15'h0000, pcm_en}, 16'h0000);
		init_busy <= 1'b0;
		step(a0, `SERL_RSP_INV_ACC, 3'b000);
		sr(8'h02);
		st(8'h00);
		check("pcm", {15'h0000, pcm_en}, 16'h0001);
		for (int k = 0; k < 8; k++) begin
			v = rnd();
			{sgn, arm, acc} <= v[11:0];
			step(af(1'b0, v[12], v[11], v[10]), {6'h11, v[9:0]}, 3'b100);
		end
		{sgn, arm} <= 2'b00;
		for (int k = 0; k < 8; k++)
			step(k == 3 ? rf(1'b0, 5'h10, 8'h01) : a0 ^ bad[k], `SERL_RSP_SPI_ERR, 3'b000,
				k == 6 ? 15 : k == 7 ? 17 : 16, k == 4 ? 1 : k == 5 ? 2 : 0);
		check("pcm", {15'h0000, pcm_en}, 16'h0001);
		for (int k = 0; k < 3; k++)
			step(af(k == 0, 1'b0, k == 1, k == 2), `SERL_RSP_INV_ACC, 3'b000);
		step(a0, {6'h11, acc}, 3'b100);
		for (int k = 0; k < 9; k++)
			step(rf(k < 4, bad_a[k], 8'h00), `SERL_RSP_INV_REG, 3'b000);
		v = rnd();
		rdat <= v[15:8];
		step(rf(1'b1, 5'h00, v[7:0]), {8'h81, v[7:0]}, 3'b010);
		check("write", {3'h0, addr, wdat}, {8'h00, v[7:0]});
		step(rf(1'b0, 5'h10, 8'h00), {8'h80, v[15:8]}, 3'b001);
		lock <= 1'b1;
		step(rf(1'b1, 5'h00, v[7:0]), `SERL_RSP_INV_REG, 3'b000);
		step(rf(1'b1, 5'h10, v[7:0]), {8'h81, v[7:0]}, 3'b010);
		lock <= 1'b0;
		ms(a0, 3'b000);
		st(8'h08);
		ms(rf(1'b1, 5'h00, 8'h5a), 3'b010);
		ms(rf(1'b0, 5'h10, 8'h00), 3'b000);
		ms(rf(1'b0, 5'h0e, 8'h00), 3'b000);
		ms(af(1'b1, 1'b0, 1'b0, 1'b0), 3'b000);
		st(8'h08);
		sr(8'h08);
		st(8'h00);
		for (int k = 0; k < 2; k++) begin
			v = rnd();
			acc <= v[9:0];
			{offo, modo} <= k ? 2'b01 : 2'b10;
			step(a0, {6'h12, v[9:0]}, 3'b100);
			{offo, modo} <= 2'b00;
			step(a0, {6'h12, v[9:0]}, 3'b100);
			step(a0, {6'h11, v[9:0]}, 3'b100);
			sr(k ? 8'h20 : 8'h10);
		end
		pf(3'b010);
		step(a0, `SERL_RSP_INT_ERR, 3'b000);
		sr(8'h04);
		step(a0, {6'h11, acc}, 3'b100);
		pf(3'b001);
		step(a0, `SERL_RSP_ST_ERR, 3'b000);
		flt <= 3'b001;
		sr(8'h04);
		flt <= 3'b000;
		step(a0, `SERL_RSP_ST_ERR, 3'b000);
		sr(8'h04);
		step(a0, {6'h11, acc}, 3'b100);
		lgf <= 1'b1;
		step(a0, `SERL_RSP_INT_ERR, 3'b000);
		lgf <= 1'b0;
		sr(8'h04);
		step(a0, {6'h11, acc}, 3'b100);
		lock <= 1'b1;
		pf(3'b010);
		step(a0, `SERL_RSP_INT_ERR, 3'b000);
		sr(8'h04);
		step(a0, `SERL_RSP_INT_ERR, 3'b000);
		sr(8'h04);
		resetn_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		lock <= 1'b0;
		resetn_i <= 1'b1;
		pend = `SERL_RSP_SPI_ERR;
		step(a0, `SERL_RSP_INV_ACC, 3'b000);
		sr(8'h02);
		pf(3'b100);
		step(a0, `SERL_RSP_INT_ERR, 3'b000);
		sr(8'h04);
		step(a0, `SERL_RSP_INT_ERR, 3'b000);
		sr(8'h04);
		report_and_stop();
	end
endmodule

// ### test/serl_host_model.sv
// Link host model: issues one mode 0 frame of counted clock rises per call
// Assumes the bench resolves the MISO wire and hands it in on miso_i
module serl_host_model (
	// Link pins
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Mode 1 holds the clock high at select, mode 2 at release
	task automatic xfer(input logic [15:0] cmd, input int rises, input int mode,
		output logic [15:0] rsp);
		rsp = 16'h0000;
		if (mode == 1) begin
			sclk_o = 1'b1;
			#40;
		end
		cs_n_o = 1'b0;
		#40;
		sclk_o = 1'b0;
		for (int i = 0; i < rises; i++) begin
			mosi_o = cmd[(15 - i) & 15];
			#40;
			sclk_o = 1'b1;
			rsp = {rsp[14:0], miso_i};
			#40;
			if (!(mode == 2 && i == rises - 1))
				sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#40;
		sclk_o = 1'b0;
		#100;
	endtask
endmodule
